//--- core/lfs_linefeed_ctrl.sv
// linefeed state selector for one channel of a line interface
// assumes hook and power-fault levels arrive asynchronously from the line
// driver side and software settings come from logic on ref_clk
`timescale 1ns/1ps
module lfs_linefeed_ctrl
    import lfs_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // software state field
    input  wire logic                  state_wr,
    input  wire logic [LFS_STATE_W-1:0] line_state_select,
    output logic      [LFS_STATE_W-1:0] line_state_readback,
    output logic                       power_fault_open,
    // software feed settings
    input  wire logic                  voc_wr,
    input  wire logic [LFS_VOLT_W-1:0] voc_value,
    input  wire logic                  loop_current_ceiling_wr,
    input  wire logic [LFS_LOOP_CURRENT_CEILING_W-1:0] loop_current_ceiling_value,
    input  wire logic                  vcm_wr,
    input  wire logic [LFS_VOLT_W-1:0] vcm_value,
    output logic      [LFS_VOLT_W-1:0] open_circuit_voltage_setting,
    output logic      [LFS_LOOP_CURRENT_CEILING_W-1:0] loop_current_ceiling,
    output logic      [LFS_VOLT_W-1:0] common_mode_offset,
    // line side status, asynchronous
    input  wire logic                  off_hook,
    input  wire logic                  driver_overpower,
    // line driver controls
    output logic                       tip_drive_en,
    output logic                       ring_drive_en,
    output logic                       polarity_reverse,
    output logic                       ringing_en,
    output logic                       audio_path_en,
    output logic                       low_power
);

    lfs_state_t sel_q;
    lfs_state_t eff_state;
    logic       fault_q;
    logic [1:0] hook_sync_q;
    logic [1:0] pwr_sync_q;
    logic       hook;
    logic       pwr_fault;

    // two-stage synchronisers; only the second stage is read
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hook_sync_q <= 2'h0;
            pwr_sync_q  <= 2'h0;
        end
        else
        begin
            hook_sync_q <= {hook_sync_q[0], off_hook};
            pwr_sync_q  <= {pwr_sync_q[0], driver_overpower};
        end
    end

    assign hook      = hook_sync_q[1];
    assign pwr_fault = pwr_sync_q[1];

    // software selection, opens itself on reset
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            sel_q <= lfs_state_t'(LFS_STATE_RST);
        else if (state_wr)
            sel_q <= lfs_state_t'(line_state_select);
    end

    // fault latch: a fault in the write cycle wins, so the channel stays safe
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            fault_q <= 1'b0;
        else if (pwr_fault)
            fault_q <= 1'b1;
        else if (state_wr)
            fault_q <= 1'b0;
    end

    assign eff_state = (fault_q || pwr_fault) ? LFS_OPEN : sel_q;

    function automatic logic is_active(input lfs_state_t s);
        is_active = (s == LFS_FWD_ACTIVE) || (s == LFS_REV_ACTIVE);
    endfunction

    // driver decode
    always_comb
    begin
        tip_drive_en     = 1'b0;
        ring_drive_en    = 1'b0;
        polarity_reverse = 1'b0;
        ringing_en       = 1'b0;
        audio_path_en    = 1'b0;
        low_power        = 1'b0;
        unique case (eff_state)
            LFS_OPEN:
            begin
                tip_drive_en  = 1'b0;
                ring_drive_en = 1'b0;
            end
            LFS_FWD_ACTIVE:
            begin
                tip_drive_en  = 1'b1;
                ring_drive_en = 1'b1;
                audio_path_en = hook;
                low_power     = !hook;
            end
            LFS_FWD_OHT:
            begin
                tip_drive_en  = 1'b1;
                ring_drive_en = 1'b1;
                audio_path_en = 1'b1;
            end
            LFS_TIP_OPEN:
            begin
                ring_drive_en = 1'b1;
                audio_path_en = hook;
            end
            LFS_RINGING:
            begin
                tip_drive_en  = 1'b1;
                ring_drive_en = 1'b1;
                ringing_en    = 1'b1;
            end
            LFS_REV_ACTIVE:
            begin
                tip_drive_en     = 1'b1;
                ring_drive_en    = 1'b1;
                polarity_reverse = 1'b1;
                audio_path_en    = hook;
                low_power        = !hook;
            end
            LFS_REV_OHT:
            begin
                tip_drive_en     = 1'b1;
                ring_drive_en    = 1'b1;
                polarity_reverse = 1'b1;
                audio_path_en    = 1'b1;
            end
            LFS_RING_OPEN:
            begin
                tip_drive_en  = 1'b1;
                audio_path_en = hook;
            end
        endcase
    end

    assign line_state_readback = eff_state;
    assign power_fault_open    = fault_q;

    // feed settings; voltage codes clamp at the 63.3 V ceiling
    lfs_setting_reg #(
        .W       (LFS_VOLT_W),
        .RST_VAL (LFS_VOC_RST),
        .MAX_VAL (LFS_VOC_MAX)
    ) u_voc (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .load      (voc_wr),
        .value     (voc_value),
        .setting_q (open_circuit_voltage_setting)
    );

    lfs_setting_reg #(
        .W       (LFS_LOOP_CURRENT_CEILING_W),
        .RST_VAL (LFS_LOOP_CURRENT_CEILING_RST),
        .MAX_VAL (5'h1F)
    ) u_loop_current_ceiling (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .load      (loop_current_ceiling_wr),
        .value     (loop_current_ceiling_value),
        .setting_q (loop_current_ceiling)
    );

    lfs_setting_reg #(
        .W       (LFS_VOLT_W),
        .RST_VAL (LFS_VCM_RST),
        .MAX_VAL (LFS_VOC_MAX)
    ) u_vcm (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .load      (vcm_wr),
        .value     (vcm_value),
        .setting_q (common_mode_offset)
    );

    // hook and fault are checked after their synchronisers, as the decode sees them
    chk_open_hiz: assert property (@(posedge ref_clk) disable iff (!nrst)
        (line_state_readback == LFS_OPEN) |-> (!tip_drive_en && !ring_drive_en))
        else $error("open state drives a lead");

    chk_reset_open: assert property (@(posedge ref_clk)
        $rose(nrst) |-> (line_state_readback == LFS_OPEN))
        else $error("reset did not leave the channel open");

    // a one-cycle fault followed at once by a write may legally reopen the channel
    chk_fault_forces_open: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(pwr_fault) |-> (line_state_readback == LFS_OPEN) [*2]
            ##1 ($past(state_wr && !pwr_fault) || (line_state_readback == LFS_OPEN)))
        else $error("power fault did not open the channel");

    chk_fault_no_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        pwr_fault |-> (!tip_drive_en && !ring_drive_en && !ringing_en))
        else $error("lead driven during power fault");

    chk_fault_holds_open: assert property (@(posedge ref_clk) disable iff (!nrst)
        (fault_q && !state_wr) |=> (line_state_readback == LFS_OPEN))
        else $error("channel left open without a write");

    chk_write_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state_wr && !pwr_fault)
            |=> (pwr_fault || (line_state_readback == $past(line_state_select))))
        else $error("written state not taken");

    chk_active_audio_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        (is_active(eff_state) && !hook) |-> (!audio_path_en && low_power))
        else $error("active on-hook not in standby");

    chk_offhook_audio: assert property (@(posedge ref_clk) disable iff (!nrst)
        (is_active(eff_state) && hook) |-> (audio_path_en && !low_power))
        else $error("active off-hook without audio");

    chk_fwd_polarity: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_FWD_ACTIVE) |-> (tip_drive_en && ring_drive_en && !polarity_reverse))
        else $error("forward active leads wrong");

    chk_standby_active: assert property (@(posedge ref_clk) disable iff (!nrst)
        low_power |-> is_active(eff_state))
        else $error("low power outside active states");

    chk_oht_audio_on: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_FWD_OHT || eff_state == LFS_REV_OHT) |-> audio_path_en)
        else $error("on-hook transmission without audio");

    chk_oht_fed: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_FWD_OHT) |-> (tip_drive_en && ring_drive_en && !polarity_reverse))
        else $error("forward transmission leads wrong");

    chk_ground_start: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_TIP_OPEN) |-> (!tip_drive_en && ring_drive_en))
        else $error("tip open leads wrong");

    chk_ring_open: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_RING_OPEN) |-> (tip_drive_en && !ring_drive_en))
        else $error("ring open leads wrong");

    chk_ringing_drive: assert property (@(posedge ref_clk) disable iff (!nrst)
        ringing_en |-> (eff_state == LFS_RINGING))
        else $error("ringing outside ringing state");

    chk_ringing_on: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_RINGING) |-> ringing_en)
        else $error("ringing state without ringing");

    chk_reverse_pol: assert property (@(posedge ref_clk) disable iff (!nrst)
        polarity_reverse |-> (eff_state inside {LFS_REV_ACTIVE, LFS_REV_OHT}))
        else $error("reverse polarity in wrong state");

    chk_rev_active_pol: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_REV_ACTIVE) |-> (polarity_reverse && tip_drive_en && ring_drive_en))
        else $error("reverse active leads wrong");

    chk_rev_oht_pol: assert property (@(posedge ref_clk) disable iff (!nrst)
        (eff_state == LFS_REV_OHT) |-> (polarity_reverse && audio_path_en))
        else $error("reverse transmission wrong");

    chk_voc_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        (voc_wr && voc_value <= LFS_VOC_MAX)
            |=> (open_circuit_voltage_setting == $past(voc_value)))
        else $error("voc setting not loaded");

    chk_voc_clamp: assert property (@(posedge ref_clk) disable iff (!nrst)
        (voc_wr && voc_value > LFS_VOC_MAX) |=> (open_circuit_voltage_setting == LFS_VOC_MAX))
        else $error("voc setting not clamped");

    chk_voc_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !voc_wr |=> $stable(open_circuit_voltage_setting))
        else $error("voc setting moved without a write");

    chk_loop_current_ceiling_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        loop_current_ceiling_wr |=> (loop_current_ceiling == $past(loop_current_ceiling_value)))
        else $error("current ceiling not loaded");

    chk_vcm_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        (vcm_wr && vcm_value <= LFS_VOC_MAX) |=> (common_mode_offset == $past(vcm_value)))
        else $error("common-mode setting not loaded");

    chk_vcm_default: assert property (@(posedge ref_clk)
        $rose(nrst) |-> (common_mode_offset == LFS_VCM_RST))
        else $error("common-mode default wrong");

endmodule

//--- core/lfs_pkg.sv
// linefeed state selector: shared codes, field widths and reset values
// assumes one 10 MHz clock and software-facing settings held as plain ports
package lfs_pkg;

    typedef enum logic [2:0] {
        LFS_OPEN       = 3'b000,
        LFS_FWD_ACTIVE = 3'b001,
        LFS_FWD_OHT    = 3'b010,
        LFS_TIP_OPEN   = 3'b011,
        LFS_RINGING    = 3'b100,
        LFS_REV_ACTIVE = 3'b101,
        LFS_REV_OHT    = 3'b110,
        LFS_RING_OPEN  = 3'b111
    } lfs_state_t;

    localparam int          LFS_STATE_W   = 3;
    localparam int          LFS_VOLT_W    = 15;
    localparam int          LFS_LOOP_CURRENT_CEILING_W    = 5;
    // voltage code lsb 4.907 mV; 1 V step is about 204 codes
    localparam logic [14:0] LFS_VOC_RST   = 15'h0000;
    localparam logic [14:0] LFS_VOC_MAX   = 15'h3266;
    // current ceiling 18..45 mA in 0.87 mA steps: codes 0..31
    localparam logic [4:0]  LFS_LOOP_CURRENT_CEILING_RST  = 5'h00;
    // 3 V common-mode default, 3 / 4.907 mV rounded
    localparam logic [14:0] LFS_VCM_RST   = 15'h0263;
    localparam logic [2:0]  LFS_STATE_RST = 3'h0;

endpackage

//--- core/lfs_setting_reg.sv
// one loadable feed setting register with reset default and ceiling clamp
// assumes load strobe and value come from logic on the same clock
`timescale 1ns/1ps
module lfs_setting_reg
    import lfs_pkg::*;
#(
    parameter int          W       = 15,
    parameter logic [W-1:0] RST_VAL = '0,
    parameter logic [W-1:0] MAX_VAL = '1
)
(
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    // load side
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // held setting
    output logic      [W-1:0] setting_q
);

    // refused while elaborating: a default above the ceiling could never be restored by a load
    if (W < 1 || RST_VAL > MAX_VAL)
        $error("lfs_setting_reg: bad width or default");

    // values above the ceiling are clamped rather than refused
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            setting_q <= RST_VAL;
        else if (load)
            setting_q <= (value > MAX_VAL) ? MAX_VAL : value;
    end

endmodule

//--- verif/lfs_linefeed_ctrl_tb.sv
// self-checking bench for the linefeed selector, with a loop model
// assumes 10 MHz ref_clk and inputs driven on the falling edge
`timescale 1ns/1ps
module lfs_linefeed_ctrl_tb
    import lfs_pkg::*;
;
    // expected {tip,ring,pol,ringing,audio,low_power} on-hook, and care mask
    localparam logic [5:0] EXP_T [8] = '{6'h00, 6'h31, 6'h32, 6'h10,
                                         6'h04, 6'h39, 6'h3A, 6'h20};
    localparam logic [5:0] MSK_T [8] = '{6'h34, 6'h3B, 6'h3E, 6'h34,
                                         6'h04, 6'h3B, 6'h3E, 6'h34};
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        state_wr = 1'b0;
    logic [2:0]  line_state_select = 3'h0;
    logic [2:0]  line_state_readback;
    logic        power_fault_open;
    logic        voc_wr = 1'b0;
    logic [14:0] voc_value = 15'h0000;
    logic        loop_current_ceiling_wr = 1'b0;
    logic [4:0]  loop_current_ceiling_value = 5'h00;
    logic        vcm_wr = 1'b0;
    logic [14:0] vcm_value = 15'h0000;
    logic [14:0] open_circuit_voltage_setting;
    logic [4:0]  loop_current_ceiling;
    logic [14:0] common_mode_offset;
    logic        off_hook;
    logic        driver_overpower;
    logic        hook_cmd = 1'b0;
    logic        fault_cmd = 1'b0;
    logic        tip_drive_en;
    logic        ring_drive_en;
    logic        polarity_reverse;
    logic        ringing_en;
    logic        audio_path_en;
    logic        low_power;
    logic [5:0]  drv;
    int          errors = 0;
    int          comparisons = 0;

    assign drv = {tip_drive_en, ring_drive_en, polarity_reverse,
                  ringing_en, audio_path_en, low_power};

    always #50 ref_clk = ~ref_clk;

    lfs_linefeed_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .state_wr(state_wr),
        .line_state_select(line_state_select), .line_state_readback(line_state_readback),
        .power_fault_open(power_fault_open), .voc_wr(voc_wr), .voc_value(voc_value),
        .loop_current_ceiling_wr(loop_current_ceiling_wr), .loop_current_ceiling_value(loop_current_ceiling_value), .vcm_wr(vcm_wr), .vcm_value(vcm_value),
        .open_circuit_voltage_setting(open_circuit_voltage_setting),
        .loop_current_ceiling(loop_current_ceiling), .common_mode_offset(common_mode_offset),
        .off_hook(off_hook), .driver_overpower(driver_overpower),
        .tip_drive_en(tip_drive_en), .ring_drive_en(ring_drive_en),
        .polarity_reverse(polarity_reverse), .ringing_en(ringing_en),
        .audio_path_en(audio_path_en), .low_power(low_power));

    lfs_loop_model loop_model (.hook_cmd(hook_cmd), .fault_cmd(fault_cmd),
        .tip_drive_en(tip_drive_en), .ring_drive_en(ring_drive_en),
        .off_hook(off_hook), .driver_overpower(driver_overpower));

    task automatic finish_test();
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_val(input logic [14:0] got, input logic [14:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    // only the cared bits are compared; the rest are left to the designer
    task automatic check_drive(input logic [5:0] exp, input logic [5:0] msk);
        comparisons = comparisons + 1;
        if ((drv & msk) !== (exp & msk))
        begin
            errors = errors + 1;
            $display("mismatch at %0t: drive %b expected %b", $time, drv, exp);
        end
    endtask

    task automatic write_state(input logic [2:0] code);
        line_state_select = code;
        state_wr = 1'b1;
        @(negedge ref_clk);
        state_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic write_setting(input int which, input logic [14:0] val);
        voc_value = val;
        loop_current_ceiling_value = val[4:0];
        vcm_value = val;
        voc_wr = (which == 0);
        loop_current_ceiling_wr = (which == 1);
        vcm_wr = (which == 2);
        @(negedge ref_clk);
        voc_wr = 1'b0;
        loop_current_ceiling_wr = 1'b0;
        vcm_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    // async line inputs pass a two-flop synchroniser before they act
    task automatic settle();
        repeat (4) @(negedge ref_clk);
    endtask

    initial
    begin
        repeat (2000) @(posedge ref_clk);
        errors = errors + 1;
        finish_test();
    end

    initial
    begin
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        check_val(15'(line_state_readback), 15'h0000);
        check_drive(6'h00, 6'h34);
        check_val(15'(power_fault_open), 15'h0000);
        check_val(open_circuit_voltage_setting, LFS_VOC_RST);
        check_val(15'(loop_current_ceiling), 15'(LFS_LOOP_CURRENT_CEILING_RST));
        check_val(common_mode_offset, 15'h0263);
        for (int i = 0; i < 8; i++)
        begin
            write_state(3'(i));
            check_val(15'(line_state_readback), 15'(i));
            check_drive(EXP_T[i], MSK_T[i]);
        end
        write_setting(0, 15'h3266);
        check_val(open_circuit_voltage_setting, 15'h3266);
        write_setting(0, 15'h7FFF);
        check_val(open_circuit_voltage_setting, 15'h3266);
        write_setting(1, 15'h001F);
        check_val(15'(loop_current_ceiling), 15'h001F);
        write_setting(2, 15'h0FFF);
        check_val(common_mode_offset, 15'h0FFF);
        write_state(3'h1);
        hook_cmd = 1'b1;
        settle();
        check_drive(6'h32, 6'h3B);
        write_state(3'h5);
        settle();
        check_drive(6'h3A, 6'h3B);
        hook_cmd = 1'b0;
        fault_cmd = 1'b1;
        settle();
        check_val(15'(line_state_readback), 15'h0000);
        check_drive(6'h00, 6'h34);
        check_val(15'(power_fault_open), 15'h0001);
        write_state(3'h1);
        check_val(15'(line_state_readback), 15'h0000);
        fault_cmd = 1'b0;
        settle();
        check_val(15'(line_state_readback), 15'h0000);
        check_val(15'(power_fault_open), 15'h0001);
        write_state(3'h1);
        check_val(15'(line_state_readback), 15'h0001);
        @(negedge ref_clk);
        check_val(15'(power_fault_open), 15'h0000);
        nrst = 1'b0;
        @(negedge ref_clk);
        nrst = 1'b1;
        check_val(15'(line_state_readback), 15'h0000);
        check_val(open_circuit_voltage_setting, LFS_VOC_RST);
        check_val(common_mode_offset, LFS_VCM_RST);
        finish_test();
    end
endmodule

//--- verif/lfs_loop_model.sv
// subscriber loop and high-voltage driver model for the linefeed selector
// assumes hook and fault commands come from the bench on the falling edge
`timescale 1ns/1ps
module lfs_loop_model
(
    // bench commands
    input  wire logic hook_cmd,
    input  wire logic fault_cmd,
    // driver controls from the selector
    input  wire logic tip_drive_en,
    input  wire logic ring_drive_en,
    // line status back to the selector
    output logic      off_hook,
    output logic      driver_overpower
);
    // a closed loop only draws current when at least one lead is fed,
    // so an open channel never reports off-hook
    assign off_hook         = hook_cmd & (tip_drive_en | ring_drive_en);
    assign driver_overpower = fault_cmd;
endmodule
